// >>> include/uad_link_if.sv
// Cable between the device end and the hub port end, with pull-ups, pull-downs and bus power.
// Assumes both ends run on mclk; line levels are resolved here from the drive enables.
`timescale 1ns/1ps
`default_nettype none
interface uad_link_if;
	logic dp_out;
	logic dp_oe;
	logic dm_out;
	logic dm_oe;
	logic pullup_dp;
	logic pullup_dm;
	logic vbus_on;
	logic hide_pullup;
	logic dp_line;
	logic dm_line;
	logic attach_detect_pin;

	// Undriven line: pull-up wins only while powered and not hidden, else the hub pull-down
	assign dp_line = dp_oe ? dp_out : (pullup_dp & vbus_on & ~hide_pullup);
	assign dm_line = dm_oe ? dm_out : (pullup_dm & vbus_on & ~hide_pullup);
	assign attach_detect_pin = vbus_on;

	modport dev (
		input  dp_line,
		input  dm_line,
		input  attach_detect_pin,
		output dp_out,
		output dp_oe,
		output dm_out,
		output dm_oe,
		output pullup_dp,
		output pullup_dm
	);

	modport hub (
		input  dp_line,
		input  dm_line,
		output vbus_on,
		output hide_pullup
	);
endinterface : uad_link_if
`default_nettype wire

// >>> include/uad_pkg.sv
// Shared constants for the attach/detach and line-state logic of a USB device port and its hub port.
// Assumes a 100 MHz mclk on both ends and a 32-bit AXI4-Lite register bus on the device end.
package uad_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] IRQ_EN_OFS  = 8'h04;
	localparam logic [7:0] IRQ_REQ_OFS = 8'h08;

	// ==========================================================
	// Field positions
	localparam int CTRL_RX_PD_BIT     = 0;
	localparam int CTRL_TX_PD_BIT     = 1;
	localparam int CTRL_LOW_SPEED_BIT = 2;
	localparam int CTRL_BUS_PWR_BIT   = 3;
	localparam int CTRL_ATTACHED_BIT  = 7;
	localparam int CTRL_WR_W          = 4;
	localparam int IRQ_ATTACH_BIT     = 0;
	localparam int IRQ_DETACH_BIT     = 1;
	localparam int IRQ_SE0_BIT        = 2;
	localparam int IRQ_W              = 3;

	// ==========================================================
	// Reset values
	localparam logic [CTRL_WR_W-1:0] CTRL_RESET    = 4'h0;
	localparam logic [IRQ_W-1:0]     IRQ_EN_RESET  = 3'h0;
	localparam logic [IRQ_W-1:0]     IRQ_REQ_RESET = 3'h0;

	// ==========================================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int PERSIST_TIME_NS = 2500;
	// Least time: round up
	localparam int PERSIST_CYCLES  = (PERSIST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NCO_W           = 17;
	localparam logic [NCO_W-1:0] CLK_RATE_KHZ = 17'h186a0;  // 100000 kHz
	localparam logic [NCO_W-1:0] FS_RATE_KHZ  = 17'h02ee0;  // 12000 kHz
	localparam logic [NCO_W-1:0] LS_RATE_KHZ  = 17'h005dc;  // 1500 kHz

	// ==========================================================
	// Hub port states
	typedef enum logic [0:0] {
		HUB_DETACHED = 1'b0,
		HUB_ATTACHED = 1'b1
	} uad_hub_state_type;

endpackage : uad_pkg

// >>> rtl/uad_device_end.sv
// Device end: transceiver enables and bit timing, single-ended-zero and attach/detach detection,
// request flags and enables behind an AXI4-Lite slave. Assumes the link lines and the attach-detect
// pin are asynchronous to mclk.
// How it works
// - Bit timing at 12 or 1.5 Mbit/s
// - Receiver and transmitter powered down separately
// - Drivers released whenever transmitter is off
// - Both lines low flags single-ended zero while the receiver is powered
// - Hub reads speed from pull-up position
// - Hub connects after idle over 2.5 us
// - Hub disconnects after zero over 2.5 us
// - Attach sets attached flag and attach request
// - Detach clears attached flag; self-powered it sets detach request, bus-powered the attach request
// - Bus-powered: attached flag mirrors the pin
// - Bus-powered: pin changes still raise requests
// - Hub may hide device by dropping pull-up
// - Attach request forwarded only when enabled
// - Detach request forwarded only when enabled
// - Zero request forwarded only when enabled
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module uad_device_end #(
	parameter int ADDR_W = 8
) (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	uad_link_if.dev                link,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              tx_active,
	input  wire logic              tx_bit,
	output logic                   tx_bit_taken,
	output logic                   rx_bit,
	output logic                   rx_bit_valid,
	output logic                   device_irq
);
	localparam int NW = uad_pkg::NCO_W;

	logic [uad_pkg::CTRL_WR_W-1:0] ctrl_reg;
	logic [uad_pkg::IRQ_W-1:0]     irq_en_reg;
	logic [uad_pkg::IRQ_W-1:0]     irq_req_reg;
	logic [uad_pkg::IRQ_W-1:0]     irq_set;
	logic [uad_pkg::IRQ_W-1:0]     irq_clr;
	logic [2:0]                    sync1_reg;
	logic [2:0]                    sync2_reg;
	logic                          pin_prev_reg;
	logic                          attached_reg;
	logic                          se0_prev_reg;
	logic                          se0_now;
	logic                          pin_rise;
	logic                          pin_fall;
	logic                          rx_pd;
	logic                          tx_pd;
	logic                          low_speed;
	logic                          bus_powered;
	logic [NW-1:0]                 nco_reg;
	logic [NW-1:0]                 nco_sum;
	logic                          bit_strobe;
	logic                          drive_reg;
	logic                          dp_out_reg;
	logic                          aw_hold_reg;
	logic                          w_hold_reg;
	logic [ADDR_W-1:0]             awaddr_reg;
	logic [31:0]                   wdata_reg;
	logic [3:0]                    wstrb_reg;
	logic                          wr_do;
	logic                          wr_hit;
	logic [7:0]                    wr_ofs;
	logic [7:0]                    rd_ofs;
	logic [31:0]                   rd_word;
	logic                          rd_hit;

	assign rx_pd       = ctrl_reg[uad_pkg::CTRL_RX_PD_BIT];
	assign tx_pd       = ctrl_reg[uad_pkg::CTRL_TX_PD_BIT];
	assign low_speed   = ctrl_reg[uad_pkg::CTRL_LOW_SPEED_BIT];
	assign bus_powered = ctrl_reg[uad_pkg::CTRL_BUS_PWR_BIT];

	// ==========================================================
	// Synchronisers: attach pin, D+, D-
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {link.attach_detect_pin, link.dp_line, link.dm_line};
			sync2_reg <= sync1_reg;
		end
	end

	// ==========================================================
	// Attach detection
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pin_prev_reg <= 1'b0;
			attached_reg <= 1'b0;
			se0_prev_reg <= 1'b1;  // Unpowered lines sit at zero; avoids a false edge after reset
		end else begin
			pin_prev_reg <= sync2_reg[2];
			// Set on attach, cleared on detach, so it tracks the pin in either mode
			attached_reg <= sync2_reg[2];
			se0_prev_reg <= se0_now;
		end
	end
	assign pin_rise = sync2_reg[2] & ~pin_prev_reg;
	assign pin_fall = ~sync2_reg[2] & pin_prev_reg;
	// Receiver powered down sees nothing on the lines
	assign se0_now  = ~rx_pd & ~sync2_reg[1] & ~sync2_reg[0];

	always_comb begin
		irq_set = '0;
		if (bus_powered) begin
			irq_set[uad_pkg::IRQ_ATTACH_BIT] = pin_rise | pin_fall;
		end else begin
			irq_set[uad_pkg::IRQ_ATTACH_BIT] = pin_rise;
			irq_set[uad_pkg::IRQ_DETACH_BIT] = pin_fall;
		end
		irq_set[uad_pkg::IRQ_SE0_BIT] = se0_now & ~se0_prev_reg;
	end

	// ==========================================================
	// Request flags, write one to clear
	assign irq_clr = (wr_do && wr_hit && wr_ofs == uad_pkg::IRQ_REQ_OFS && wstrb_reg[0]) ?
		wdata_reg[uad_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			irq_req_reg <= uad_pkg::IRQ_REQ_RESET;
		end else begin
			irq_req_reg <= (irq_req_reg & ~irq_clr) | irq_set;
		end
	end
	assign device_irq = |(irq_req_reg & irq_en_reg);

	// ==========================================================
	// Bit timing: fractional divider, exact at both rates
	assign nco_sum    = nco_reg + (low_speed ? uad_pkg::LS_RATE_KHZ : uad_pkg::FS_RATE_KHZ);
	assign bit_strobe = (nco_sum >= uad_pkg::CLK_RATE_KHZ);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			nco_reg <= '0;
		end else if (bit_strobe) begin
			nco_reg <= nco_sum - uad_pkg::CLK_RATE_KHZ;
		end else begin
			nco_reg <= nco_sum;
		end
	end

	// ==========================================================
	// Transmitter: released at once when off so the hub can drive
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			drive_reg    <= 1'b0;
			dp_out_reg   <= 1'b0;
			tx_bit_taken <= 1'b0;
		end else begin
			tx_bit_taken <= 1'b0;
			if (tx_pd || !tx_active) begin
				drive_reg <= 1'b0;
			end else if (bit_strobe) begin
				drive_reg    <= 1'b1;
				dp_out_reg   <= tx_bit;
				tx_bit_taken <= 1'b1;
			end
		end
	end
	assign link.dp_out    = dp_out_reg;
	assign link.dm_out    = ~dp_out_reg;
	assign link.dp_oe     = drive_reg;
	assign link.dm_oe     = drive_reg;
	assign link.pullup_dp = ~low_speed;
	assign link.pullup_dm = low_speed;

	// ==========================================================
	// Receiver: samples D+ once a bit while not driving
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rx_bit       <= 1'b0;
			rx_bit_valid <= 1'b0;
		end else begin
			rx_bit_valid <= 1'b0;
			if (bit_strobe && !rx_pd && !drive_reg) begin
				rx_bit       <= sync2_reg[1];
				rx_bit_valid <= 1'b1;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite write: address and data held, write done when both present
	assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
	assign wr_do         = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
	assign wr_ofs        = 8'(awaddr_reg);
	assign wr_hit        = (wr_ofs == uad_pkg::CTRL_OFS) || (wr_ofs == uad_pkg::IRQ_EN_OFS) ||
		(wr_ofs == uad_pkg::IRQ_REQ_OFS);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			aw_hold_reg  <= 1'b0;
			w_hold_reg   <= 1'b0;
			awaddr_reg   <= '0;
			wdata_reg    <= 32'h0;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= uad_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? uad_pkg::RESP_OKAY : uad_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ctrl_reg   <= uad_pkg::CTRL_RESET;
			irq_en_reg <= uad_pkg::IRQ_EN_RESET;
		end else if (wr_do && wstrb_reg[0]) begin
			if (wr_ofs == uad_pkg::CTRL_OFS) begin
				ctrl_reg <= wdata_reg[uad_pkg::CTRL_WR_W-1:0];
			end else if (wr_ofs == uad_pkg::IRQ_EN_OFS) begin
				irq_en_reg <= wdata_reg[uad_pkg::IRQ_W-1:0];
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_ofs        = 8'(s_axi_araddr);

	always_comb begin
		rd_word = 32'h0;
		rd_hit  = 1'b1;
		if (rd_ofs == uad_pkg::CTRL_OFS) begin
			rd_word[uad_pkg::CTRL_WR_W-1:0]   = ctrl_reg;
			rd_word[uad_pkg::CTRL_ATTACHED_BIT] = attached_reg;
		end else if (rd_ofs == uad_pkg::IRQ_EN_OFS) begin
			rd_word[uad_pkg::IRQ_W-1:0] = irq_en_reg;
		end else if (rd_ofs == uad_pkg::IRQ_REQ_OFS) begin
			rd_word[uad_pkg::IRQ_W-1:0] = irq_req_reg;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= uad_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? uad_pkg::RESP_OKAY : uad_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : uad_device_end
`default_nettype wire

// >>> rtl/uad_hub_end.sv
// Hub port end: powers the cable, may hide the device, detects connect, speed and disconnect.
// Assumes the cable levels arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module uad_hub_end #(
	parameter int PERSIST_CYCLES = uad_pkg::PERSIST_CYCLES
) (
	input  wire logic   mclk,
	input  wire logic   reset_n,
	uad_link_if.hub     link,
	input  wire logic   vbus_enable,
	input  wire logic   hide_device,
	output logic        port_connected,
	output logic        port_full_speed,
	output logic        connect_event,
	output logic        disconnect_event
);
	localparam int CNT_W = $clog2(PERSIST_CYCLES + 2);
	localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(PERSIST_CYCLES);

	logic [1:0]                 sync1_reg;
	logic [1:0]                 sync2_reg;
	logic [CNT_W-1:0]           count_reg;
	uad_pkg::uad_hub_state_type state_reg;
	logic                       vbus_reg;
	logic                       hide_reg;
	logic                       idle_j;
	logic                       se0;

	// ==========================================================
	// Pin drive
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			vbus_reg <= 1'b0;
			hide_reg <= 1'b0;
		end else begin
			vbus_reg <= vbus_enable;
			hide_reg <= hide_device;
		end
	end
	assign link.vbus_on     = vbus_reg;
	assign link.hide_pullup = hide_reg;

	// ==========================================================
	// Line synchroniser
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
		end else begin
			sync1_reg <= {link.dp_line, link.dm_line};
			sync2_reg <= sync1_reg;
		end
	end
	assign idle_j = sync2_reg[1] ^ sync2_reg[0];
	assign se0    = ~sync2_reg[1] & ~sync2_reg[0];

	// ==========================================================
	// Persistence timing: must exceed the limit, so one count past it
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			count_reg <= '0;
		end else if ((state_reg == uad_pkg::HUB_DETACHED) ? !idle_j : !se0) begin
			count_reg <= '0;
		end else if (count_reg <= CNT_LIMIT) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg        <= uad_pkg::HUB_DETACHED;
			port_full_speed  <= 1'b0;
			connect_event    <= 1'b0;
			disconnect_event <= 1'b0;
		end else begin
			connect_event    <= 1'b0;
			disconnect_event <= 1'b0;
			case (state_reg)
				uad_pkg::HUB_DETACHED: begin
					if (idle_j && count_reg > CNT_LIMIT) begin
						state_reg       <= uad_pkg::HUB_ATTACHED;
						port_full_speed <= sync2_reg[1];
						connect_event   <= 1'b1;
					end
				end
				default: begin
					if (se0 && count_reg > CNT_LIMIT) begin
						state_reg        <= uad_pkg::HUB_DETACHED;
						disconnect_event <= 1'b1;
					end
				end
			endcase
		end
	end
	assign port_connected = (state_reg == uad_pkg::HUB_ATTACHED);
endmodule : uad_hub_end
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench: device end and hub port end joined by the link interface.
// Assumes the bench is the AXI4-Lite master and drives the hub power and hide inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int PERSIST = 8;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [1:0]  resp;
	} uad_row_type;
	logic        mclk, reset_n, tx_active, tx_bit, vbus_enable, hide_device;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        tx_bit_taken, rx_bit, rx_bit_valid, device_irq;
	logic        port_connected, port_full_speed, connect_event, disconnect_event;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          bad_count = 0;
	int          checks_done = 0;
	uad_row_type rows [6] = '{
		'{uad_pkg::CTRL_OFS, 32'h8b, 32'h0b, uad_pkg::RESP_OKAY},
		'{uad_pkg::IRQ_EN_OFS, 32'hff, 32'h07, uad_pkg::RESP_OKAY},
		'{uad_pkg::IRQ_REQ_OFS, 32'hff, 32'h00, uad_pkg::RESP_OKAY},
		'{8'h0c, 32'hff, 32'h00, uad_pkg::RESP_SLVERR},
		'{uad_pkg::CTRL_OFS, 32'h00, 32'h00, uad_pkg::RESP_OKAY},
		'{uad_pkg::IRQ_EN_OFS, 32'h00, 32'h00, uad_pkg::RESP_OKAY}};

	uad_link_if link();
	uad_hub_end #(.PERSIST_CYCLES(PERSIST)) i_uad_hub_end (.mclk, .reset_n, .link(link), .vbus_enable,
		.hide_device, .port_connected, .port_full_speed, .connect_event, .disconnect_event);
	uad_device_end i_uad_device_end (.mclk, .reset_n, .link(link), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_active, .tx_bit, .tx_bit_taken, .rx_bit,
		.rx_bit_valid, .device_irq);
	uad_properties #(.PERSIST_CYCLES(PERSIST)) i_uad_properties (.mclk, .reset_n,
		.dp_out(link.dp_out), .dp_oe(link.dp_oe), .dm_out(link.dm_out), .dm_oe(link.dm_oe),
		.pullup_dp(link.pullup_dp), .pullup_dm(link.pullup_dm), .hide_pullup(link.hide_pullup),
		.dp_line(link.dp_line), .dm_line(link.dm_line), .tx_active, .tx_bit, .tx_bit_taken,
		.rx_bit_valid, .hide_device, .port_connected, .connect_event, .disconnect_event);

	always #5 mclk = ~mclk;

	// ======
	// Helpers
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd

	task automatic wc(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", 32'(uad_pkg::RESP_OKAY), 32'(r));
	endtask : wc

	task automatic rc(input string name, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(name, e, d);
		chk("rresp", 32'(uad_pkg::RESP_OKAY), 32'(r));
	endtask : rc

	function automatic logic sel(input int k);
		case (k)
			0: return connect_event;
			1: return disconnect_event;
			2: return tx_bit_taken;
			default: return rx_bit_valid;
		endcase
	endfunction : sel

	// Returns lim+1 when the pulse never came
	task automatic wt(input int k, input int lim, output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (!sel(k) && n <= lim);
	endtask : wt

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		final_report();
	end

	// ======
	// Main sequence
	initial begin
		int          n;
		logic [31:0] d;
		logic [1:0]  r;
		{mclk, reset_n, tx_active, tx_bit, vbus_enable, hide_device} = 6'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		rc("ctrl_rst", uad_pkg::CTRL_OFS, 32'h0);
		rc("req_rst", uad_pkg::IRQ_REQ_OFS, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata, r);
			chk("bresp", 32'(rows[i].resp), 32'(r));
			rd(rows[i].addr, d, r);
			chk("rresp", 32'(rows[i].resp), 32'(r));
			if (rows[i].resp === uad_pkg::RESP_OKAY)
				chk("rdata", rows[i].rdata, d);
		end
		// Receiver back on with the cable unpowered: zero on both lines is a new entry
		rc("se0_rxon", uad_pkg::IRQ_REQ_OFS, 32'h4);
		wc(uad_pkg::IRQ_REQ_OFS, 32'h7);
		// Self-powered attach, seen by the hub as a full-speed connect
		wc(uad_pkg::IRQ_EN_OFS, 32'h7);
		vbus_enable <= 1'b1;
		wt(0, 300, n);
		chk("conn_time", 1, 32'(n > PERSIST && n <= 300));
		chk("full_speed", 1, 32'(port_full_speed));
		chk("connected", 1, 32'(port_connected));
		rc("attached", uad_pkg::CTRL_OFS, 32'h80);
		rc("attach_req", uad_pkg::IRQ_REQ_OFS, 32'h1);
		chk("irq_on", 1, 32'(device_irq));
		wc(uad_pkg::IRQ_REQ_OFS, 32'h7);
		rc("req_clr", uad_pkg::IRQ_REQ_OFS, 32'h0);
		chk("irq_off", 0, 32'(device_irq));
		// Transmit at full speed, then power down each half
		tx_bit <= 1'b1;
		tx_active <= 1'b1;
		wt(2, 300, n);
		chk("oe", 1, 32'(link.dp_oe));
		chk("dp_out", 1, 32'(link.dp_out));
		tx_bit <= 1'b0;
		wt(2, 300, n);
		chk("fs_gap", 1, 32'(n == 8 || n == 9));
		chk("dp_out0", 0, 32'(link.dp_out));
		wc(uad_pkg::CTRL_OFS, 32'h2);
		repeat (2) @(posedge mclk);
		chk("oe_pd", 0, 32'(link.dp_oe));
		wt(2, 30, n);
		chk("tx_quiet", 31, 32'(n));
		wt(3, 300, n);
		chk("rx_idle", 1, 32'(rx_bit));
		wc(uad_pkg::CTRL_OFS, 32'h3);
		tx_active <= 1'b0;
		wt(3, 200, n);
		chk("rx_quiet", 201, 32'(n));
		// Low speed: pull-up moves to D-, slower strobes
		wc(uad_pkg::CTRL_OFS, 32'h4);
		wt(3, 300, n);
		wt(3, 300, n);
		chk("ls_gap", 1, 32'(n == 66 || n == 67));
		chk("rx_ls", 0, 32'(rx_bit));
		// Hub hides the device: zero on both lines
		wc(uad_pkg::IRQ_EN_OFS, 32'h4);
		hide_device <= 1'b1;
		wt(1, 300, n);
		chk("disc_time", 1, 32'(n > PERSIST && n <= 300));
		chk("disconnected", 0, 32'(port_connected));
		chk("irq_se0", 1, 32'(device_irq));
		rc("se0_req", uad_pkg::IRQ_REQ_OFS, 32'h4);
		hide_device <= 1'b0;
		wt(0, 300, n);
		chk("low_speed", 0, 32'(port_full_speed));
		wc(uad_pkg::IRQ_REQ_OFS, 32'h7);
		// Self-powered detach
		wc(uad_pkg::IRQ_EN_OFS, 32'h2);
		vbus_enable <= 1'b0;
		repeat (6) @(posedge mclk);
		rc("detached", uad_pkg::CTRL_OFS, 32'h4);
		rc("detach_req", uad_pkg::IRQ_REQ_OFS, 32'h6);
		chk("irq_det", 1, 32'(device_irq));
		wc(uad_pkg::IRQ_EN_OFS, 32'h0);
		chk("irq_mask", 0, 32'(device_irq));
		// Bus-powered: pin acts as a plain input with change requests
		wc(uad_pkg::IRQ_REQ_OFS, 32'h7);
		wc(uad_pkg::CTRL_OFS, 32'h8);
		wc(uad_pkg::IRQ_EN_OFS, 32'h1);
		vbus_enable <= 1'b1;
		repeat (6) @(posedge mclk);
		rc("bp_attached", uad_pkg::CTRL_OFS, 32'h88);
		rc("bp_rise_req", uad_pkg::IRQ_REQ_OFS, 32'h1);
		chk("bp_irq", 1, 32'(device_irq));
		wc(uad_pkg::IRQ_REQ_OFS, 32'h7);
		vbus_enable <= 1'b0;
		repeat (6) @(posedge mclk);
		rc("bp_detached", uad_pkg::CTRL_OFS, 32'h8);
		rc("bp_fall_req", uad_pkg::IRQ_REQ_OFS, 32'h5);
		final_report();
	end
endmodule : tb_top
`default_nettype wire

// >>> verif/uad_properties.sv
// Checker for the cable joining the device end and the hub port end.
// Assumes one mclk domain; tb_top instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module uad_properties #(
	parameter int PERSIST_CYCLES = uad_pkg::PERSIST_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic dp_out,
	input wire logic dp_oe,
	input wire logic dm_out,
	input wire logic dm_oe,
	input wire logic pullup_dp,
	input wire logic pullup_dm,
	input wire logic hide_pullup,
	input wire logic dp_line,
	input wire logic dm_line,
	input wire logic tx_active,
	input wire logic tx_bit,
	input wire logic tx_bit_taken,
	input wire logic rx_bit_valid,
	input wire logic hide_device,
	input wire logic port_connected,
	input wire logic connect_event,
	input wire logic disconnect_event
);
	logic [7:0] hi_run_reg;
	logic [7:0] lo_run_reg;
	logic [3:0] hi_age_reg;
	logic [3:0] lo_age_reg;

	// ======
	// Raw run lengths and how long ago each last reached the limit
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			hi_run_reg <= 8'h00;
			lo_run_reg <= 8'h00;
			hi_age_reg <= 4'hf;
			lo_age_reg <= 4'hf;
		end else begin
			hi_run_reg <= (dp_line ^ dm_line) ? hi_run_reg + {7'h00, hi_run_reg != 8'hff} : 8'h00;
			lo_run_reg <= (!dp_line && !dm_line) ? lo_run_reg + {7'h00, lo_run_reg != 8'hff} : 8'h00;
			hi_age_reg <= (hi_run_reg >= PERSIST_CYCLES) ? 4'h0 : hi_age_reg + {3'h0, hi_age_reg != 4'hf};
			lo_age_reg <= (lo_run_reg >= PERSIST_CYCLES) ? 4'h0 : lo_age_reg + {3'h0, lo_age_reg != 4'hf};
		end
	end

	// ======
	// Properties
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	// Strobes at 12 or 1.5 MHz are never closer than 8 clocks
	sequence s_quiet7;
		!tx_bit_taken [*7];
	endsequence

	AST_DRIVE_PAIR: assert property (dm_oe == dp_oe && (!dp_oe || dm_out != dp_out))
		else $error("D- drive is not the complement of D+");
	AST_PULLUP_ONE: assert property (pullup_dp != pullup_dm)
		else $error("Pull-up not on exactly one line");
	AST_HIDE_FOLLOW: assert property ($past(reset_n) |-> hide_pullup == $past(hide_device))
		else $error("Hide control did not follow its input");
	AST_TX_TAKEN: assert property (tx_bit_taken |-> dp_oe && dp_out == $past(tx_bit))
		else $error("Taken bit not on the line");
	AST_OE_START: assert property ($rose(dp_oe) |-> tx_bit_taken)
		else $error("Driver enabled without a taken bit");
	AST_OE_STOP: assert property (!tx_active |=> !dp_oe)
		else $error("Driver still enabled after transmit ended");
	AST_STROBE_GAP: assert property (tx_bit_taken |=> s_quiet7)
		else $error("Bit strobes too close");
	AST_RX_LISTEN: assert property (rx_bit_valid |-> !$past(dp_oe))
		else $error("Receive strobe while driving");
	AST_CONNECT_AGE: assert property (connect_event |-> hi_age_reg < 4'h8)
		else $error("Connect without a long enough idle run");
	AST_DISCONNECT_AGE: assert property (disconnect_event |-> lo_age_reg < 4'h8)
		else $error("Disconnect without a long enough zero run");
	AST_CONNECT_PULSE: assert property ($rose(port_connected) |-> connect_event)
		else $error("Port connected without a connect event");
endmodule : uad_properties
`default_nettype wire
